// ### pkg/lprs_pkg.sv
package lprs_pkg;
    // machine word and line geometry
    localparam int WORD_W = 40;
    localparam int ORDER_W = 8;
    localparam int ADDR_W = 12;
    localparam int ROWS_PER_LINE = 18;
    localparam logic [7:0] ORDER_LINE_PRINT = 8'hce;
    // clock rate and timing
    localparam int CLK_HZ = 25000000;
    localparam real CYCLE_GAP_MS = 1.5;
    localparam int CYCLE_GAP_CLKS = int'($floor(CYCLE_GAP_MS * CLK_HZ / 1000.0));
    localparam int LINES_PER_SEC = 15;
    localparam int REV_CLKS = CLK_HZ / LINES_PER_SEC;
    localparam int CNT_W = 24;
    localparam logic [4:0] ROW_LAST = 5'h11;
    localparam logic [WORD_W-1:0] ROW_RESET = '1;
    typedef enum logic [1:0] {
        LPRS_IDLE = 2'b00,
        LPRS_SYNC = 2'b01,
        LPRS_LINE = 2'b10
    } lprs_state_t;
endpackage

// ### hdl/lprs_edge_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser with rising-edge pulse on the settled level
module lprs_edge_sync
(
    input wire logic mclk, // system clock
    input wire logic nrst, // sync reset, active low
    input wire logic ce, // clock enable
    input wire logic din, // asynchronous level
    output logic rise // one-cycle pulse on rising edge
);
    logic meta_ff;
    logic sync_ff;
    logic last_ff;

    // first stage feeds only the second stage
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end
        else if (ce)
        begin
            meta_ff <= din;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign rise = ce & sync_ff & ~last_ff;
endmodule // lprs_edge_sync

// ### hdl/lprs_line_printer.sv
`timescale 1ns/1ps
// Functional notes
// - forty row bits drive forty column wheels
// - zero bit prints, one bit suppresses
// - eighteen print cycles make one line
// - whole line within one cylinder revolution
// - cylinder turns always; any revolution starts
// - print cycles spaced about 1.5 ms
// - first order starts; later orders strobe
// - print order F down to minus
// - order code ce prints from row register
// - address field of print order ignored
// - at most fifteen lines per second
// - row register supplies the wheel bits
module lprs_line_printer
    import lprs_pkg::*;
(
    input wire logic mclk, // 25 mhz system clock
    input wire logic nrst, // sync reset, active low
    input wire logic ce, // clock enable, freezes state when low
    input wire logic instr_valid, // one-cycle instruction execute strobe
    input wire logic [ORDER_W-1:0] instr_order, // order part of instruction
    input wire logic [ADDR_W-1:0] instr_addr, // address part, unused by print
    input wire logic [WORD_W-1:0] print_row_register, // arithmetic register contents
    input wire logic cyl_index, // cylinder home mark from mechanism, async
    output logic instr_done, // print order accepted, one-cycle pulse
    output logic [WORD_W-1:0] hammer_n, // per-wheel command, low prints
    output logic hammer_fire, // one-cycle strike strobe
    output logic [4:0] row_index, // cycles completed in current line
    output logic line_busy, // line in progress
    output logic late_order // sticky: order gap exceeded 1.5 ms, or the turn ended before the line
);
    lprs_state_t state_ff, nxt_state;
    logic [CNT_W-1:0] gap_ff;
    logic [4:0] row_ff;
    logic [WORD_W-1:0] row_word_ff;
    logic fire_ff;
    logic late_ff;
    logic done_ff;
    logic home_rise;
    logic is_print;
    logic pending_ff;
    logic [WORD_W-1:0] pend_word_ff;
    logic gap_over;
    logic line_overrun;
    logic line_last;
    logic strike_go;

    // order decode; only the order part of the instruction is looked at
    function automatic logic order_is_print(input logic [ORDER_W-1:0] code);
        begin
            return (code == ORDER_LINE_PRINT);
        end
    endfunction

    // async cylinder mark brought onto mclk
    lprs_edge_sync u_home
    (
        .mclk (mclk),
        .nrst (nrst),
        .ce (ce),
        .din (cyl_index),
        .rise (home_rise)
    );

    // address bits take no part in decode
    assign is_print = instr_valid && order_is_print(instr_order);
    assign gap_over = (gap_ff >= CNT_W'(CYCLE_GAP_CLKS));

    // the strike that closes the line; a mark in that same cycle is harmless
    assign line_last = fire_ff && (row_ff == ROW_LAST);
    // a further mark while the line runs: the turn ended before all rows were struck,
    // so the wheels are no longer aligned with the rows still to come
    assign line_overrun = (state_ff == LPRS_LINE) && home_rise && !line_last;
    // one strike per latched order, never on two edges in a row
    assign strike_go = (state_ff == LPRS_LINE) && pending_ff && !fire_ff;

    // line sequencer: idle, wait for cylinder mark, print cycles
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            LPRS_IDLE:
                if (is_print)
                    nxt_state = LPRS_SYNC; // first order actuates
            LPRS_SYNC:
                if (home_rise)
                    nxt_state = LPRS_LINE; // any turn, from its mark
            LPRS_LINE:
                if (line_last)
                    nxt_state = LPRS_IDLE;
                else if (gap_over)
                    nxt_state = LPRS_IDLE; // abandoned line, order came too late
                else if (line_overrun)
                    nxt_state = LPRS_IDLE; // turn ended before the line
            default:
                nxt_state = LPRS_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
            state_ff <= LPRS_IDLE;
        else if (ce)
            state_ff <= nxt_state;
    end

    // line rate needs no timer of its own: every line starts at a cylinder mark
    // and must end before the next one, so two lines never share a turn.
    // trade-off: a line ordered just after a mark waits almost a whole turn,
    // which keeps the logic free of any assumption about the cylinder speed.

    // latch row word when an order arrives, except while waiting for the mark; fire on the cycle slot
    // the word is captured at the order, since the register may change next
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            pending_ff <= 1'b0;
            pend_word_ff <= ROW_RESET;
        end
        else if (ce)
        begin
            if (is_print && state_ff != LPRS_SYNC)
            begin
                pending_ff <= 1'b1;
                pend_word_ff <= print_row_register;
            end
            else if (fire_ff)
                pending_ff <= 1'b0;
        end
    end

    // gap timer between cycles; each later order is the strobe for its cycle
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            gap_ff <= '0;
        else if (ce)
        begin
            if (state_ff != LPRS_LINE || fire_ff)
                gap_ff <= '0;
            else if (!gap_over)
                gap_ff <= gap_ff + 1'b1;
        end
    end

    // strike one wheel row per order while the line runs
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            fire_ff <= 1'b0;
            row_word_ff <= ROW_RESET;
            row_ff <= '0;
        end
        else if (ce)
        begin
            fire_ff <= strike_go;
            if (strike_go)
                row_word_ff <= pend_word_ff;
            if (state_ff == LPRS_IDLE)
                row_ff <= '0;
            else if (fire_ff)
                row_ff <= row_ff + 1'b1;
        end
    end

    // acknowledge of every print order, in any state
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            done_ff <= 1'b0;
        else if (ce)
            done_ff <= is_print;
    end

    // late flag: order gap too long, or the turn ran out; set wins over the clear
    // the clear only comes with a fresh actuation, so software sees a lost line
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            late_ff <= 1'b0;
        else if (ce)
        begin
            if (state_ff == LPRS_LINE && gap_over && !pending_ff)
                late_ff <= 1'b1;
            else if (line_overrun)
                late_ff <= 1'b1;
            else if (is_print && state_ff == LPRS_IDLE)
                late_ff <= 1'b0;
        end
    end

    // outputs straight from the flops except line_busy, so the mechanism sees no glitches
    assign hammer_n = row_word_ff; // zero bit prints its column
    assign hammer_fire = fire_ff;
    assign row_index = row_ff;
    assign line_busy = (state_ff != LPRS_IDLE);
    assign late_order = late_ff;
    assign instr_done = done_ff;
endmodule // lprs_line_printer

// ### sim/lprs_monitor.sv
`timescale 1ns/1ps
// port watcher; the bench holds ce high
module lprs_monitor
    import lprs_pkg::*;
(
    input wire logic mclk, // clock
    input wire logic nrst, // reset, low
    input wire logic ce, // enable
    input wire logic instr_valid, // strobe
    input wire logic [ORDER_W-1:0] instr_order, // order
    input wire logic instr_done, // accepted
    input wire logic [WORD_W-1:0] hammer_n, // wheels
    input wire logic hammer_fire, // strike
    input wire logic [4:0] row_index, // count
    input wire logic line_busy, // busy
    input wire logic late_order // sticky
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // accept pulse only ever follows a print order
    a_done_cause: assert property (instr_done |-> $past(instr_valid) && $past(instr_order) == ORDER_LINE_PRINT)
        else $error("done without order");
    // wheel word moves only with a strike
    a_word_holds: assert property (!hammer_fire |-> $stable(hammer_n))
        else $error("word changed");
    a_count_step: assert property (hammer_fire |=> row_index == $past(row_index) + 5'h01)
        else $error("count step");
    a_count_bound: assert property (row_index <= ROW_LAST + 5'h01)
        else $error("count range");
    a_fire_busy: assert property (hammer_fire |-> $past(line_busy))
        else $error("fire while idle");
    a_idle_quiet: assert property (!line_busy && !$past(line_busy) |-> !hammer_fire)
        else $error("idle strike");
    a_fire_pulse: assert property (hammer_fire |=> !hammer_fire)
        else $error("long strike");
    a_late_sticky: assert property (late_order && !(instr_valid && instr_order == ORDER_LINE_PRINT && !line_busy)
        |=> late_order)
        else $error("late cleared");
    // reset must clear regardless of the reset disable
    a_reset_clear: assert property (disable iff (1'b0) !nrst && ce |=> hammer_n == ROW_RESET && !line_busy)
        else $error("reset state");
    c_fire: cover property (hammer_fire);
    c_full: cover property (row_index == 5'h12);
    c_done: cover property (instr_done);
    c_late: cover property (late_order);
endmodule // lprs_monitor
bind lprs_line_printer lprs_monitor lprs_monitor_i (.mclk(mclk), .nrst(nrst), .ce(ce),
    .instr_valid(instr_valid), .instr_order(instr_order), .instr_done(instr_done), .hammer_n(hammer_n),
    .hammer_fire(hammer_fire), .row_index(row_index), .line_busy(line_busy), .late_order(late_order));

// ### sim/lprs_cylinder.sv
`timescale 1ns/1ps
// type cylinder: home mark each turn, printing or not; revolution shortened for run time
module lprs_cylinder
#(
    parameter int REV_NS = 20000 // one turn
)
(
    output logic cyl_index // home mark, async
);
    // free-running, phase unrelated to mclk
    initial
    begin
        cyl_index = 1'b0;
        #7;
        forever
        begin
            cyl_index = 1'b1;
            #400;
            cyl_index = 1'b0;
            #(REV_NS - 400);
        end
    end
endmodule // lprs_cylinder

// ### sim/tb_lprs_line_printer.sv
`timescale 1ns/1ps
module tb_lprs_line_printer;
    import lprs_pkg::*;
    logic mclk, nrst, instr_valid, cyl_index, instr_done, hammer_fire, line_busy, late_order, seen;
    logic [ORDER_W-1:0] instr_order;
    logic [ADDR_W-1:0] instr_addr;
    logic [WORD_W-1:0] print_row_register, hammer_n;
    logic [4:0] row_index;
    logic [WORD_W-1:0] row_word [ROWS_PER_LINE];
    int fail_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    int k;
    lprs_line_printer lprs_line_printer_i (.mclk(mclk), .nrst(nrst), .ce(1'b1), .instr_valid(instr_valid),
        .instr_order(instr_order), .instr_addr(instr_addr), .print_row_register(print_row_register),
        .cyl_index(cyl_index), .instr_done(instr_done), .hammer_n(hammer_n), .hammer_fire(hammer_fire),
        .row_index(row_index), .line_busy(line_busy), .late_order(late_order));
    lprs_cylinder lprs_cylinder_i (.cyl_index(cyl_index));
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic check(string name, logic [WORD_W-1:0] got, logic [WORD_W-1:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // one order; row word held until the strike lands, next order comes at once
    task automatic order(logic [7:0] op, logic [ADDR_W-1:0] ad, logic [WORD_W-1:0] w, logic ok, int lim);
        @(negedge mclk);
        instr_valid = 1'b1;
        instr_order = op;
        instr_addr = ad;
        print_row_register = w;
        @(negedge mclk);
        instr_valid = 1'b0;
        seen = 1'b0;
        for (k = 0; k < lim && hammer_fire !== 1'b1; k++)
        begin
            seen = seen | instr_done;
            @(negedge mclk);
        end
        check("done", seen, op == ORDER_LINE_PRINT);
        check("fire", hammer_fire, ok);
        if (ok)
            check("wheels", hammer_n, w);
    endtask
    // hang guard: one line with waits is far shorter
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            finish_test;
        end
    end
    initial
    begin
        nrst = 1'b0;
        instr_valid = 1'b0;
        instr_order = 8'h00;
        instr_addr = 12'h000;
        print_row_register = '1;
        // row image, row 1 minus up to row 18 letter F, one printing column each
        for (int i = 0; i < ROWS_PER_LINE; i++)
            row_word[i] = ~(40'h1 << (2 * i));
        repeat (20) @(negedge mclk);
        check("rst wheels", hammer_n, ROW_RESET);
        check("rst count", row_index, 5'h00);
        nrst = 1'b1;
        // rows from 18 down to 1, address varied, a foreign order refused mid-line
        for (int r = ROWS_PER_LINE; r > 0; r--)
        begin
            if (r == 9)
                order(8'hcf, 12'hfff, 40'h0, 1'b0, 3);
            order(ORDER_LINE_PRINT, 12'h0ab * r[11:0], row_word[r-1], 1'b1, r == ROWS_PER_LINE ? 3000 : 4);
            @(negedge mclk);
            check("count", row_index, 19 - r);
        end
        repeat (2) @(negedge mclk);
        check("idle", line_busy, 1'b0);
        check("late", late_order, 1'b0);
        // next order is a fresh actuation waiting for the mark
        order(ORDER_LINE_PRINT, 12'h000, row_word[0], 1'b0, 2);
        check("restart", line_busy, 1'b1);
        // no further orders: the next mark starts the line with one strike, the mark after ends it unfinished
        repeat (1100) @(negedge mclk);
        check("abort idle", line_busy, 1'b0);
        check("abort late", late_order, 1'b1);
        check("abort count", row_index, 5'h00);
        check("abort wheels", hammer_n, row_word[0]);
        nrst = 1'b0;
        repeat (3) @(negedge mclk);
        check("rst idle", line_busy, 1'b0);
        finish_test;
    end
endmodule // tb_lprs_line_printer
